// *** inc/express_link_slot_map.vh ***
`ifndef EXPRESS_LINK_SLOT_MAP_VH
`define EXPRESS_LINK_SLOT_MAP_VH
// ==============================
// Register byte addresses
`define ADDR_LINK 8'hc0
`define ADDR_SLOT_CAP 8'hc4
`define ADDR_SLOT 8'hc8
`define ADDR_IRQ_STATUS 8'he0
`define ADDR_IRQ_ENABLE 8'he4
`define ADDR_IRQ_CLEAR 8'he8
// ==============================
// Link control fields
`define LC_PWR_LO 0
`define LC_PWR_HI 1
`define LC_RCB 3
`define LC_DISABLE 4
`define LC_RETRAIN 5
`define LC_CCLK 6
`define LC_XSYNC 7
`define LC_PWR_RESET 2'h0
// ==============================
// Link status fields
`define LS_SPEED_LO 16
`define LS_SPEED_HI 19
`define LS_WIDTH_LO 20
`define LS_WIDTH_HI 25
`define LS_TRAIN_ERR 26
`define LS_TRAINING 27
`define LS_SLOT_CLK 28
`define LS_SPEED_RESET 4'h1
`define LS_WIDTH_RESET 6'h04
// ==============================
// Slot capability fields
`define SC_BUTTON 0
`define SC_SENSOR 2
`define SC_ATTN_IND 3
`define SC_PWR_IND 4
`define SC_HP_CAPABLE 6
// ==============================
// Slot control and status fields
`define SLC_WIDTH 11
`define SLC_RESET 11'h000
`define SLS_LO 16
`define SLS_EVT_WIDTH 5
`define SLS_STATE_LO 21
// ==============================
// Interrupt events
`define IRQ_WIDTH 3
`define IRQ_SLOT_EVT 0
`define IRQ_TRAIN_ERR 1
`define IRQ_PWR_WRITE 2
`define IRQ_RESET 3'h0
`endif

// *** hdl/strap_capture.v ***
`include "express_link_slot_map.vh"
// ==============================
// Catches the hot-plug strap once, on the first edge after reset release
module strap_capture (
	input wire pclk,
	input wire presetn,
	input wire strap_in,
	output reg strap_value
);
	reg taken;

	// One-shot clocked capture; reset only loads constants
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taken <= 1'b0;
			strap_value <= 1'b0;
		end else if (!taken) begin
			taken <= 1'b1;
			strap_value <= strap_in;
		end
	end
endmodule

// *** hdl/express_link_slot_regs.v ***
`include "express_link_slot_map.vh"
module express_link_slot_regs #(
	parameter SPEED_W = 4,
	parameter WIDTH_W = 6
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire reverse_bridge,
	input wire hot_plug_strap,
	input wire [SPEED_W-1:0] link_speed_in,
	input wire [WIDTH_W-1:0] link_width_in,
	input wire link_train_error,
	input wire link_training,
	input wire link_status_valid,
	input wire [4:0] slot_events_in,
	input wire [1:0] slot_states_in,
	output reg [1:0] power_state_ctrl,
	output reg link_disable,
	output reg retrain_link,
	output reg [10:0] slot_control,
	output reg irq
);
	reg cclk_cfg;
	reg xsync;
	reg [SPEED_W-1:0] speed;
	reg [WIDTH_W-1:0] width;
	reg train_err;
	reg training;
	reg [4:0] slot_evt;
	reg [1:0] slot_st;
	reg [`IRQ_WIDTH-1:0] irq_status;
	reg [`IRQ_WIDTH-1:0] irq_enable;
	reg [`IRQ_WIDTH-1:0] next_irq_status;
	reg [`IRQ_WIDTH-1:0] irq_events;
	reg [31:0] next_rdata;
	reg mapped;
	wire hp_en;
	wire setup;
	wire wr;
	reg train_err_d;
	reg apb_state;
	reg next_apb_state;
	reg [`IRQ_WIDTH-1:0] next_irq_enable;
	reg [31:0] link_word;
	reg [31:0] slot_word;
	// Phase and per-register write strobes
	wire access;
	wire wr_link;
	wire wr_slot;
	wire wr_irq_en;
	wire wr_irq_clr;

	// Transfer phases: waiting for a setup cycle, or answering its access phase
	localparam APB_IDLE = 1'b0;
	localparam APB_ACCESS = 1'b1;
	// Width of one register word on the bus
	localparam DATA_W = 32;
	wire [DATA_W-1:0] cap_word;
	genvar cap_bit;

	strap_capture u_strap (
		.pclk(pclk),
		.presetn(presetn),
		.strap_in(hot_plug_strap),
		.strap_value(hp_en)
	);

	assign setup = psel && !penable;
	// Access phase of a transfer that this block is answering now
	assign access = psel && penable && apb_state == APB_ACCESS;
	// Writes commit at the edge that sees pready high, as the master expects
	assign wr = access && pwrite;

	// ==============================
	// Transfer phase machine; the access phase always lasts one cycle
	always @* begin
		next_apb_state = APB_IDLE;
		case (apb_state)
			APB_IDLE: begin
				if (setup)
					next_apb_state = APB_ACCESS;
			end
			APB_ACCESS: begin
				// A setup seen here starts the next transfer at once
				if (setup)
					next_apb_state = APB_ACCESS;
			end
			default: next_apb_state = APB_IDLE;
		endcase
	end

	// Phase register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			apb_state <= APB_IDLE;
		else
			apb_state <= next_apb_state;
	end

	// ==============================
	// Register write strobes; byte lane 0 gates link, enable and clear words
	assign wr_link = wr && paddr == `ADDR_LINK && pstrb[0];
	assign wr_slot = wr && paddr == `ADDR_SLOT;
	assign wr_irq_en = wr && paddr == `ADDR_IRQ_ENABLE && pstrb[0];
	assign wr_irq_clr = wr && paddr == `ADDR_IRQ_CLEAR && pstrb[0];

	// ==============================
	// Slot capability word; only the hot-plug presence bits follow the strap
	generate
		for (cap_bit = 0; cap_bit < DATA_W; cap_bit = cap_bit + 1) begin : cap_bits
			if (cap_bit == `SC_BUTTON || cap_bit == `SC_SENSOR || cap_bit == `SC_ATTN_IND ||
				cap_bit == `SC_PWR_IND || cap_bit == `SC_HP_CAPABLE) begin : hp_bit
				assign cap_word[cap_bit] = hp_en;
			end else begin : fixed_bit
				assign cap_word[cap_bit] = 1'b0;
			end
		end
	endgenerate

	// ==============================
	// Address decode: the words that answer without an error
	always @* begin
		mapped = 1'b0;
		case (paddr)
			`ADDR_LINK,
			`ADDR_SLOT_CAP,
			`ADDR_SLOT,
			`ADDR_IRQ_STATUS,
			`ADDR_IRQ_ENABLE,
			`ADDR_IRQ_CLEAR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Link control and link status word
	always @* begin
		link_word = 32'h00000000;
		link_word[`LC_PWR_HI:`LC_PWR_LO] = power_state_ctrl;
		link_word[`LC_RCB] = 1'b0;
		link_word[`LC_DISABLE] = link_disable;
		link_word[`LC_RETRAIN] = retrain_link;
		link_word[`LC_CCLK] = cclk_cfg;
		link_word[`LC_XSYNC] = xsync;
		link_word[`LS_SPEED_HI:`LS_SPEED_LO] = speed;
		link_word[`LS_WIDTH_HI:`LS_WIDTH_LO] = width;
		link_word[`LS_TRAIN_ERR] = train_err;
		link_word[`LS_TRAINING] = training;
		link_word[`LS_SLOT_CLK] = 1'b1;
	end

	// Slot control and slot status word
	always @* begin
		slot_word = 32'h00000000;
		slot_word[`SLC_WIDTH-1:0] = slot_control;
		slot_word[`SLS_LO+`SLS_EVT_WIDTH-1:`SLS_LO] = slot_evt;
		slot_word[`SLS_STATE_LO+1:`SLS_STATE_LO] = slot_st;
	end

	// Read mux; the clear word and unmapped words read as zero
	always @* begin
		case (paddr)
			`ADDR_LINK: next_rdata = link_word;
			`ADDR_SLOT_CAP: next_rdata = cap_word;
			`ADDR_SLOT: next_rdata = slot_word;
			`ADDR_IRQ_STATUS: next_rdata = {{(DATA_W-`IRQ_WIDTH){1'b0}}, irq_status};
			`ADDR_IRQ_ENABLE: next_rdata = {{(DATA_W-`IRQ_WIDTH){1'b0}}, irq_enable};
			`ADDR_IRQ_CLEAR: next_rdata = 32'h00000000;
			default: next_rdata = 32'h00000000;
		endcase
	end

	// ==============================
	// APB answer: one wait-free access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= next_apb_state == APB_ACCESS;
			pslverr <= setup && !mapped;
		end
	end

	// Read data, loaded at the setup edge and held until the next read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (setup && !pwrite)
			prdata <= next_rdata;
	end

	// ==============================
	// Link control; disable and retrain only move on the reverse bridge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_state_ctrl <= `LC_PWR_RESET;
			link_disable <= 1'b0;
			retrain_link <= 1'b0;
			cclk_cfg <= 1'b0;
			xsync <= 1'b0;
		end else if (wr_link) begin
			power_state_ctrl <= pwdata[`LC_PWR_HI:`LC_PWR_LO];
			cclk_cfg <= pwdata[`LC_CCLK];
			xsync <= pwdata[`LC_XSYNC];
			if (reverse_bridge) begin
				link_disable <= pwdata[`LC_DISABLE];
				retrain_link <= pwdata[`LC_RETRAIN];
			end
		end
	end

	// ==============================
	// Slot control enables and indicators, byte lanes 0 and 1
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_control <= `SLC_RESET;
		end else if (wr_slot) begin
			if (pstrb[0])
				slot_control[7:0] <= pwdata[7:0];
			if (pstrb[1])
				slot_control[`SLC_WIDTH-1:8] <= pwdata[`SLC_WIDTH-1:8];
		end
	end

	// ==============================
	// Link status capture from the link training logic
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed <= `LS_SPEED_RESET;
			width <= `LS_WIDTH_RESET;
			train_err <= 1'b0;
			training <= 1'b0;
			train_err_d <= 1'b0;
		end else begin
			if (link_status_valid) begin
				speed <= link_speed_in;
				width <= link_width_in;
			end
			train_err <= link_train_error;
			training <= link_training;
			train_err_d <= train_err;
		end
	end

	// Slot status mirror; reads as zero while hot plug is strapped off
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_evt <= 5'h00;
			slot_st <= 2'h0;
		end else begin
			slot_evt <= hp_en ? slot_events_in : 5'h00;
			slot_st <= hp_en ? slot_states_in : 2'h0;
		end
	end

	// ==============================
	// Sticky interrupt status; a new event beats a clear in the same cycle
	always @* begin
		irq_events = `IRQ_RESET;
		irq_events[`IRQ_SLOT_EVT] = |slot_evt;
		irq_events[`IRQ_TRAIN_ERR] = train_err && !train_err_d;
		irq_events[`IRQ_PWR_WRITE] = wr_link;
		next_irq_status = irq_status;
		if (wr_irq_clr)
			next_irq_status = next_irq_status & ~pwdata[`IRQ_WIDTH-1:0];
		next_irq_status = next_irq_status | irq_events;
	end

	// Enable word as it stands after this edge
	always @* begin
		next_irq_enable = irq_enable;
		if (wr_irq_en)
			next_irq_enable = pwdata[`IRQ_WIDTH-1:0];
	end

	// Status, enable and the level interrupt, all from the next values
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= `IRQ_RESET;
			irq_enable <= `IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			irq <= |(next_irq_status & next_irq_enable);
		end
	end
endmodule

// *** verification/express_link_slot_assertions.sv ***
module express_link_slot_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire reverse_bridge,
	input wire [1:0] power_state_ctrl,
	input wire link_disable,
	input wire retrain_link,
	input wire [10:0] slot_control,
	input wire irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==============================
	// Bus phase decode
	wire su = psel && penable && pready && pwrite;
	wire wlc = su && paddr == 8'hc0 && pstrb[0];
	wire wc8 = su && paddr == 8'hc8;
	wire wsl = wc8 && pstrb[1:0] == 2'h3;
	wire rd = pready && psel && !pwrite && !pslverr;
	wire [1:0] wp = pwdata[1:0];
	wire [10:0] ws = pwdata[10:0];
	wire [1:0] lk = {link_disable, retrain_link};
	wire [4:0] hp = {prdata[6], prdata[4:2], prdata[0]};
	// ==============================
	// Properties
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_pwr; wlc |=> power_state_ctrl == $past(wp); endproperty
	a_pwr: assert property (p_pwr) else $error("power control not stored");
	property p_pwr_hold; $changed(power_state_ctrl) |-> $past(wlc); endproperty
	a_pwr_hold: assert property (p_pwr_hold) else $error("power control moved");
	property p_lc_rd;
		rd && paddr == 8'hc0 |-> prdata[3:2] == 2'h0 && prdata[1:0] == power_state_ctrl;
	endproperty
	a_lc_rd: assert property (p_lc_rd) else $error("link control readback wrong");
	property p_dis; $changed(lk) |-> $past(wlc) && $past(reverse_bridge); endproperty
	a_dis: assert property (p_dis) else $error("disable or retrain moved");
	property p_cap;
		rd && paddr == 8'hc4 |-> prdata[31:7] == 25'h0 && !prdata[5] && !prdata[1]
			&& (hp == 5'h00 || hp == 5'h1f);
	endproperty
	a_cap: assert property (p_cap) else $error("slot capability wrong");
	property p_slc; wsl |=> slot_control == $past(ws); endproperty
	a_slc: assert property (p_slc) else $error("slot control not stored");
	property p_slc_hold; $changed(slot_control) |-> $past(wc8); endproperty
	a_slc_hold: assert property (p_slc_hold) else $error("slot control moved");
	// ==============================
	// Main scenarios
	c_wlc: cover property (wlc && reverse_bridge);
	c_cap: cover property (rd && paddr == 8'hc4);
	c_irq: cover property ($rose(irq));
endmodule
bind express_link_slot_regs express_link_slot_checker chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .reverse_bridge,
	.power_state_ctrl, .link_disable, .retrain_link, .slot_control, .irq);

// *** verification/express_link_slot_regs_test.sv ***
module express_link_slot_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ==============================
	// Bench signals
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr, irq;
	logic rev = '0, strap = 1'b1, lsv = '0, lerr = '0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rs = 32'h28, d;
	logic [5:0] lwid = 6'h04;
	logic [4:0] sev = '0;
	logic [1:0] sst = '0;
	logic [65:0] notes[$], note;
	int miscompares = 0, num_checks = 0, i, k;
	express_link_slot_regs express_link_slot_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .reverse_bridge(rev),
		.hot_plug_strap(strap), .link_speed_in(4'h1), .link_width_in(lwid), .link_train_error(lerr),
		.link_training(lerr), .link_status_valid(lsv), .slot_events_in(sev), .slot_states_in(sst),
		.power_state_ctrl(), .link_disable(), .retrain_link(), .slot_control(), .irq);
	initial forever #2 pclk = ~pclk;
	// ==============================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One APB transfer; reads leave their expected word and mask in the queue
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd, input logic [65:0] n);
		@(posedge pclk);
		if (!w) notes.push_back(n);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(a, 1'b1, wd, '0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m = '1);
		apb(a, 1'b0, '0, {e, m});
	endtask
	task automatic rst(input logic s);
		strap <= s;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// Read monitor: error flag and data against the oldest note
	always @(posedge pclk) begin
		if (pready === 1'b1 && psel && !pwrite && notes.size() > 0) begin
			note = notes.pop_front();
			check({pslverr, prdata} & note[32:0], note[65:33]);
		end
	end
	// ==============================
	// Scenarios
	initial begin
		rst(1'b1);
		rd(8'hc0, 33'h10410000);
		rd(8'hc4, 33'h5d);
		strap <= 1'b0;
		rd(8'hc4, 33'h5d);
		rd(8'hc8, 33'h0);
		$display("reset values done");
		for (i = 0; i < 4; i++) begin
			rs = xs(rs);
			d = {rs[31:2], i[1:0]};
			wr(8'hc0, d);
			rd(8'hc0, {17'h1041, 8'h00, d[7:0] & 8'hc3});
		end
		rev <= 1'b1;
		wr(8'hc0, 32'hff);
		rd(8'hc0, 33'h104100f3);
		wr(8'hc0, 32'h0);
		rd(8'hc0, 33'h10410000);
		$display("link control done");
		rs = xs(rs);
		wr(8'hc8, rs);
		rd(8'hc8, {22'h0, rs[10:0]});
		sev <= 5'h15;
		sst <= 2'h2;
		lwid <= 6'h01;
		lerr <= 1'b1;
		lsv <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(8'hc8, {10'h0, 2'h2, 5'h15, 16'h0}, 33'h1ffff0000);
		rd(8'hc0, {1'b0, 4'h1, 1'b1, 1'b1, 6'h01, 4'h1, 16'h0}, 33'h1ffff0000);
		rd(8'he0, 33'h7);
		wr(8'he4, 32'h2);
		repeat (2) @(posedge pclk);
		check(irq, 1'b1);
		// Slot event still held: its status bit survives the clear
		wr(8'he8, 32'h7);
		rd(8'he0, 33'h1);
		check(irq, 1'b0);
		wr(8'he4, 32'h1);
		repeat (2) @(posedge pclk);
		check(irq, 1'b1);
		sev <= 5'h0;
		wr(8'he8, 32'h1);
		repeat (2) @(posedge pclk);
		check(irq, 1'b0);
		rd(8'he8, 33'h0);
		rd(8'h10, 33'h100000000, 33'h100000000);
		$display("interrupt and slot done");
		sev <= 5'h1f;
		rst(1'b0);
		rd(8'hc4, 33'h0);
		rd(8'hc8, 33'h0, 33'h1ffff0000);
		$display("strap off done");
		conclude();
	end
endmodule
